// File: hw/sba_pkg.sv
// Constants shared by the serial bus arbiter timer design
package sba_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets (low twelve address bits are decoded)
    // ------------------------------------------------------------------
    localparam logic [11:0] SBA_OFS_CTRL = 12'h000;
    localparam logic [11:0] SBA_OFS_DATA = 12'h004;
    localparam logic [11:0] SBA_OFS_CFG  = 12'h008;

    // ------------------------------------------------------------------
    // Control register bit positions
    // ------------------------------------------------------------------
    localparam int SBA_BIT_MODE_HI = 7;
    localparam int SBA_BIT_LOST    = 6;
    localparam int SBA_BIT_MODE_LO = 5;
    localparam int SBA_BIT_CLK_SEL = 4;
    localparam int SBA_BIT_FIN     = 3;
    localparam int SBA_BIT_RUN     = 2;
    localparam int SBA_BIT_OVF     = 1;
    localparam int SBA_BIT_TOP     = 0;

    // ------------------------------------------------------------------
    // Configuration register fields
    // ------------------------------------------------------------------
    localparam int SBA_BIT_SRC   = 0;
    localparam int SBA_PRESC_LSB = 8;

    // ------------------------------------------------------------------
    // Mode codes and reset values
    // ------------------------------------------------------------------
    localparam logic [1:0] SBA_MODE_IDLE = 2'h0;
    localparam logic [1:0] SBA_MODE_MEAS = 2'h1;
    localparam logic [1:0] SBA_MODE_ARB  = 2'h2;
    localparam logic [1:0] SBA_RST_MODE  = 2'h0;
    localparam logic       SBA_RST_CLK   = 1'b0;
    localparam logic       SBA_RST_SRC   = 1'b0;
    localparam logic [7:0] SBA_RST_PRESC = 8'h00;
    localparam logic       SBA_RST_TXD   = 1'b1;
    localparam logic       SBA_RST_RX    = 1'b1;

    // ------------------------------------------------------------------
    // Counter figures and divider terminal counts
    // ------------------------------------------------------------------
    localparam logic [8:0] SBA_CNT_MAX    = 9'h1FF;
    localparam logic [8:0] SBA_SAMPLE_BUS = 9'h038;
    localparam logic [8:0] SBA_SAMPLE_PRE = 9'h008;
    localparam logic [7:0] SBA_BUS_DIV    = 8'h03;
    localparam logic [7:0] SBA_HALF_DIV   = 8'h01;

endpackage

// File: hw/sba_tick_div.sv
// Enable-pulse divider: one tick per (div + 1) input enables
`timescale 1ns/1ns
module sba_tick_div (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       en,
    input  wire logic [7:0] div,
    output logic            tick
);

    logic [7:0] cnt_q;
    logic       tick_q;

    // A divisor lowered below the running count wraps at once, no lockup
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q  <= 8'h00;
            tick_q <= 1'b0;
        end else begin
            tick_q <= 1'b0;
            if (en) begin
                if (cnt_q >= div) begin
                    cnt_q  <= 8'h00;
                    tick_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 8'h01;
                end
            end
        end
    end

    assign tick = tick_q;

endmodule

// File: hw/sba_top.sv
// Serial bus arbiter timer: bit time measurement and bus arbitration
`timescale 1ns/1ns
module sba_top (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        osc_clk_en,
    input  wire logic        rxd_pin,
    input  wire logic        tx_internal,
    output logic             txd_pin
);

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    logic        addr_ok;
    logic        dp_wr_q;
    logic        rd_pend_q;
    logic [11:0] dp_addr_q;
    logic [31:0] hrdata_q;
    logic [31:0] rd_mux;
    logic        wr_ctl;
    logic        wr_cfg;

    // Only word transfers exist on this bus, so hsize is not decoded
    assign addr_ok = hsel & hready & htrans[1];
    assign wr_ctl  = dp_wr_q && (dp_addr_q == sba_pkg::SBA_OFS_CTRL);
    assign wr_cfg  = dp_wr_q && (dp_addr_q == sba_pkg::SBA_OFS_CFG);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_q   <= 1'b0;
            rd_pend_q <= 1'b0;
            dp_addr_q <= 12'h000;
        end else begin
            dp_wr_q   <= addr_ok & hwrite;
            rd_pend_q <= addr_ok & ~hwrite;
            if (addr_ok) begin
                dp_addr_q <= haddr[11:0];
            end
        end
    end

    // Read data is taken one cycle into the data phase, so a read right
    // after a control write already sees the cleared counter, done and overflow flags
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
        end else if (rd_pend_q) begin
            hrdata_q <= rd_mux;
        end
    end

    assign hrdata    = hrdata_q;
    assign hreadyout = ~rd_pend_q;
    assign hresp     = 1'b0;

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    logic [1:0] mode_q;
    logic       clk_sel_q;
    logic       src_q;
    logic [7:0] presc_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_q    <= sba_pkg::SBA_RST_MODE;
            clk_sel_q <= sba_pkg::SBA_RST_CLK;
        end else if (wr_ctl) begin
            mode_q    <= {hwdata[sba_pkg::SBA_BIT_MODE_HI],
                          hwdata[sba_pkg::SBA_BIT_MODE_LO]};
            clk_sel_q <= hwdata[sba_pkg::SBA_BIT_CLK_SEL];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_q   <= sba_pkg::SBA_RST_SRC;
            presc_q <= sba_pkg::SBA_RST_PRESC;
        end else if (wr_cfg) begin
            src_q   <= hwdata[sba_pkg::SBA_BIT_SRC];
            presc_q <= hwdata[sba_pkg::SBA_PRESC_LSB +: 8];
        end
    end

    // ------------------------------------------------------------------
    // Counter clock enables
    // ------------------------------------------------------------------
    logic bus_tick;
    logic pre_tick;
    logic half_tick;
    logic pre_en;
    logic tick;

    assign pre_en = src_q ? osc_clk_en : 1'b1;
    assign tick   = clk_sel_q ? half_tick : bus_tick;

    sba_tick_div u_bus_div (
        .hclk    (hclk),
        .hresetn (hresetn),
        .en      (1'b1),
        .div     (sba_pkg::SBA_BUS_DIV),
        .tick    (bus_tick)
    );

    sba_tick_div u_pre_div (
        .hclk    (hclk),
        .hresetn (hresetn),
        .en      (pre_en),
        .div     (presc_q),
        .tick    (pre_tick)
    );

    sba_tick_div u_half_div (
        .hclk    (hclk),
        .hresetn (hresetn),
        .en      (pre_tick),
        .div     (sba_pkg::SBA_HALF_DIV),
        .tick    (half_tick)
    );

    // ------------------------------------------------------------------
    // Line sampling
    // ------------------------------------------------------------------
    logic rx_s1_q;
    logic rx_s2_q;
    logic rx_s3_q;
    logic tx_prev_q;
    logic rx_fall;
    logic rx_rise;
    logic tx_rise;
    logic tx_fall;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_s1_q   <= sba_pkg::SBA_RST_RX;
            rx_s2_q   <= sba_pkg::SBA_RST_RX;
            rx_s3_q   <= sba_pkg::SBA_RST_RX;
            tx_prev_q <= sba_pkg::SBA_RST_TXD;
        end else begin
            rx_s1_q   <= rxd_pin;
            rx_s2_q   <= rx_s1_q;
            rx_s3_q   <= rx_s2_q;
            tx_prev_q <= tx_internal;
        end
    end

    assign rx_fall = rx_s3_q & ~rx_s2_q;
    assign rx_rise = ~rx_s3_q & rx_s2_q;
    assign tx_rise = ~tx_prev_q & tx_internal;
    assign tx_fall = tx_prev_q & ~tx_internal;

    // ------------------------------------------------------------------
    // Counter engine
    // ------------------------------------------------------------------
    logic [8:0] cnt_q;
    logic [8:0] cnt_d;
    logic       run_q;
    logic       run_d;
    logic       smp_q;
    logic       smp_d;
    logic       fin_q;
    logic       ovf_q;
    logic       lost_q;
    logic       fin_set;
    logic       ovf_set;
    logic       lost_set;
    logic [8:0] sample_at;

    assign sample_at = clk_sel_q ? sba_pkg::SBA_SAMPLE_PRE
                                 : sba_pkg::SBA_SAMPLE_BUS;

    always_comb begin
        cnt_d    = cnt_q;
        run_d    = run_q;
        smp_d    = smp_q;
        fin_set  = 1'b0;
        ovf_set  = 1'b0;
        lost_set = 1'b0;
        if (mode_q == sba_pkg::SBA_MODE_MEAS) begin
            if (run_q) begin
                if (clk_sel_q ? rx_rise : rx_fall) begin
                    run_d   = 1'b0;
                    fin_set = 1'b1;
                end else if (tick) begin
                    cnt_d   = cnt_q + 9'h001;
                    ovf_set = (cnt_q == sba_pkg::SBA_CNT_MAX);
                end
            end else if (!fin_q) begin
                // Level start catches a line already low at enable
                if (clk_sel_q ? ~rx_s2_q : rx_fall) begin
                    run_d = 1'b1;
                    cnt_d = 9'h000;
                end
            end
        end else if (mode_q == sba_pkg::SBA_MODE_ARB) begin
            if (lost_q) begin
                run_d = 1'b0;
            end else if (tx_rise) begin
                cnt_d = 9'h000;
                run_d = 1'b1;
                smp_d = 1'b0;
            end else if (tx_fall) begin
                // No low seen at the sample point yet, else the lost flag would be set
                cnt_d = 9'h000;
                run_d = 1'b0;
            end else if (run_q) begin
                if ((cnt_q == sample_at) && !smp_q) begin
                    smp_d    = 1'b1;
                    lost_set = ~rx_s2_q;
                end
                if (tick) begin
                    cnt_d   = cnt_q + 9'h001;
                    ovf_set = (cnt_q == sba_pkg::SBA_CNT_MAX);
                end
            end
        end else begin
            // Idle, and the reserved code, hold the counter cleared
            cnt_d = 9'h000;
            run_d = 1'b0;
            smp_d = 1'b0;
        end
        // Write clears the count last, so a flag set this cycle still lands
        if (wr_ctl) begin
            cnt_d = 9'h000;
            run_d = 1'b0;
            smp_d = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 9'h000;
            run_q <= 1'b0;
            smp_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            run_q <= run_d;
            smp_q <= smp_d;
        end
    end

    // ------------------------------------------------------------------
    // Status flags: a set in the clearing cycle wins
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fin_q <= 1'b0;
            ovf_q <= 1'b0;
        end else begin
            if (fin_set) begin
                fin_q <= 1'b1;
            end else if (wr_ctl) begin
                fin_q <= 1'b0;
            end
            if (ovf_set) begin
                ovf_q <= 1'b1;
            end else if (wr_ctl) begin
                ovf_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lost_q <= 1'b0;
        end else if (lost_set) begin
            lost_q <= 1'b1;
        end else if (wr_ctl && !hwdata[sba_pkg::SBA_BIT_MODE_HI]) begin
            lost_q <= 1'b0;
        end
    end

    // Forcing the pin high hands the line over to the winning node
    logic txd_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            txd_q <= sba_pkg::SBA_RST_TXD;
        end else begin
            txd_q <= tx_internal | lost_q;
        end
    end

    assign txd_pin = txd_q;

    // ------------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------------
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (dp_addr_q == sba_pkg::SBA_OFS_CTRL) begin
            rd_mux[sba_pkg::SBA_BIT_MODE_HI] = mode_q[1];
            rd_mux[sba_pkg::SBA_BIT_LOST]    = lost_q;
            rd_mux[sba_pkg::SBA_BIT_MODE_LO] = mode_q[0];
            rd_mux[sba_pkg::SBA_BIT_CLK_SEL] = clk_sel_q;
            rd_mux[sba_pkg::SBA_BIT_FIN]     = fin_q;
            rd_mux[sba_pkg::SBA_BIT_RUN]     = run_q;
            rd_mux[sba_pkg::SBA_BIT_OVF]     = ovf_q;
            rd_mux[sba_pkg::SBA_BIT_TOP]     = cnt_q[8];
        end else if (dp_addr_q == sba_pkg::SBA_OFS_DATA) begin
            rd_mux[7:0] = cnt_q[7:0];
        end else if (dp_addr_q == sba_pkg::SBA_OFS_CFG) begin
            rd_mux[sba_pkg::SBA_BIT_SRC]        = src_q;
            rd_mux[sba_pkg::SBA_PRESC_LSB +: 8] = presc_q;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic meas_on;
    logic arb_on;
    assign meas_on = (mode_q == sba_pkg::SBA_MODE_MEAS) && !wr_ctl;
    assign arb_on  = (mode_q == sba_pkg::SBA_MODE_ARB) && !wr_ctl;

    sequence bus_gap_seq;
        !bus_tick [*3] ##1 bus_tick;
    endsequence

    chk_bus_quarter: assert property (
        bus_tick |=> bus_gap_seq)
        else $error("bus tick not every fourth cycle");
    chk_idle_cleared: assert property (
        (mode_q == sba_pkg::SBA_MODE_IDLE) && !wr_ctl
        |=> (cnt_q == 9'h000) && !run_q)
        else $error("idle mode did not hold counter");
    chk_write_clears: assert property (
        wr_ctl && !ovf_set && !fin_set
        |=> (cnt_q == 9'h000) && !run_q && !ovf_q && !fin_q)
        else $error("control write did not clear counter");
    chk_lost_clear: assert property (
        wr_ctl && !hwdata[sba_pkg::SBA_BIT_MODE_HI] && !lost_set
        |=> !lost_q)
        else $error("lost flag survived clearing write");
    chk_fall_start: assert property (
        meas_on && !clk_sel_q && !run_q && !fin_q && rx_fall
        |=> run_q && (cnt_q == 9'h000) ##1 run_q)
        else $error("measurement did not start on fall");
    chk_low_start: assert property (
        meas_on && clk_sel_q && !run_q && !fin_q && !rx_s2_q |=> run_q)
        else $error("measurement did not start on low");
    chk_rise_stop: assert property (
        meas_on && clk_sel_q && run_q && rx_rise
        |=> !run_q && fin_q && $stable(cnt_q))
        else $error("break measurement did not stop");
    chk_ovf_set: assert property (
        run_q && tick && (cnt_d == 9'h000) && !wr_ctl
        && (cnt_q == sba_pkg::SBA_CNT_MAX) |=> ovf_q)
        else $error("overflow not flagged");
    chk_arb_restart: assert property (
        arb_on && !lost_q && tx_rise |=> run_q && (cnt_q == 9'h000))
        else $error("arbitration counter not restarted");
    chk_arb_sample: assert property (
        arb_on && !lost_q && !tx_rise && !tx_fall && run_q && !smp_q
        && (cnt_q == sample_at) && !rx_s2_q |=> lost_q ##1 txd_pin)
        else $error("low sample did not set lost flag");
    chk_tx_forced: assert property (
        lost_q |=> txd_pin)
        else $error("transmit pin not forced high");
    chk_tx_low_reset: assert property (
        arb_on && !lost_q && tx_fall |=> !run_q && (cnt_q == 9'h000))
        else $error("transmit low did not reset counter");

endmodule

// File: sim/sba_bus_node.sv
// Other node on the shared wired-AND serial line
`timescale 1ns/1ns
module sba_bus_node (
    input  wire logic txd_pin,
    input  wire logic drive_low,
    output logic      rxd_pin
);
    // Pulled-up line: a dominant low from any node always wins
    assign rxd_pin = txd_pin & ~drive_low;
endmodule

// File: sim/serial_bus_arbiter_timer_tb.sv
// Self-checking bench for the serial bus arbiter timer
`timescale 1ns/1ns
module serial_bus_arbiter_timer_tb;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic        hwrite;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hreadyout;
    logic        hresp;
    logic        tx_internal;
    logic        osc_clk_en;
    logic        drive_low;
    logic        rxd_pin;
    logic        txd_pin;
    logic [31:0] r;
    logic [31:0] ctl;
    logic [1:0]  osc_q;
    int          fail_count;
    int          comparisons;
    int          cyc;
    int          seed;
    int          c;
    int          p;
    int          d;
    int          t0;

    sba_top u_dut (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .hsel        (hsel),
        .haddr       (haddr),
        .htrans      (htrans),
        .hwrite      (hwrite),
        .hsize       (hsize),
        .hready      (hreadyout),
        .hwdata      (hwdata),
        .hrdata      (hrdata),
        .hreadyout   (hreadyout),
        .hresp       (hresp),
        .osc_clk_en  (osc_clk_en),
        .rxd_pin     (rxd_pin),
        .tx_internal (tx_internal),
        .txd_pin     (txd_pin)
    );

    sba_bus_node u_node (
        .txd_pin   (txd_pin),
        .drive_low (drive_low),
        .rxd_pin   (rxd_pin)
    );

    // ------------------------------------------------------------------
    // Clock, oscillator enable and hang guard
    // ------------------------------------------------------------------
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    always @(posedge hclk) begin
        osc_q <= (osc_q == 2'h2) ? 2'h0 : osc_q + 2'h1;
        osc_clk_en <= (osc_q == 2'h2);
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fail_count++;
            final_report();
        end
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task final_report;
        if (fail_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task check(input string n, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            fail_count++;
            $display("BAD %s expected %0h seen %0h", n, e, s);
        end
    endtask

    // Ready and read data are taken as they stand at each rising edge
    task bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
        hsel <= 1'h1;
        haddr <= {20'h00000, a};
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'h1) @(posedge hclk);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'h1) @(posedge hclk);
        r = hrdata;
    endtask

    task get_cnt;
        bus(1'h0, sba_pkg::SBA_OFS_CTRL, 32'h0);
        ctl = r;
        bus(1'h0, sba_pkg::SBA_OFS_DATA, 32'h0);
        c = {ctl[0], r[7:0]};
    endtask

    task wait_cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask

    task low(input int n);
        drive_low <= 1'h1;
        wait_cyc(n);
        drive_low <= 1'h0;
    endtask

    // Phase of the tick divider against the line edges gives slack
    function logic near(input int s, input int e);
        return (s >= e - 2) && (s <= e + 2);
    endfunction

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        hresetn = 1'h0;
        tx_internal = 1'h1;
        osc_clk_en = 1'h0;
        osc_q = 2'h0;
        drive_low = 1'h0;
        fail_count = 0;
        comparisons = 0;
        cyc = 0;
        seed = 32'h6fe6;
        wait_cyc(3);
        hresetn <= 1'h1;
        for (int i = 0; i < 4; i++) begin
            bus(1'h0, 12'(i * 4), 32'h0);
            check("reset value", r, 32'h0);
        end
        bus(1'h1, sba_pkg::SBA_OFS_CTRL, 32'h4F);
        bus(1'h0, sba_pkg::SBA_OFS_CTRL, 32'h0);
        check("read-only bits", r, 32'h0);
        bus(1'h1, sba_pkg::SBA_OFS_CTRL, 32'h10);
        bus(1'h0, sba_pkg::SBA_OFS_CTRL, 32'h0);
        check("clock select", r, 32'h10);
        bus(1'h1, 12'h00C, 32'hFF);
        bus(1'h0, 12'h00C, 32'h0);
        check("unmapped", r, 32'h0);
        // Idle mode ignores line edges
        bus(1'h1, sba_pkg::SBA_OFS_CTRL, 32'h0);
        low(5);
        wait_cyc(50);
        low(5);
        wait_cyc(20);
        get_cnt();
        check("idle count", {ctl[2], 23'h0, c[7:0]}, 32'h0);
        for (int k = 0; k < 3; k++) begin
            p = 60 + ($random(seed) & 255);
            bus(1'h1, sba_pkg::SBA_OFS_CTRL, 32'h20);
            t0 = cyc;
            low(5);
            bus(1'h0, sba_pkg::SBA_OFS_CTRL, 32'h0);
            check("running", r[2], 1'h1);
            while (cyc < t0 + p) @(posedge hclk);
            low(5);
            wait_cyc(10);
            get_cnt();
            check("bit time", near(c, p / 4), 1'h1);
            check("fin run", ctl[3:2], 2'h2);
        end
        bus(1'h1, sba_pkg::SBA_OFS_CTRL, 32'h20);
        get_cnt();
        check("cleared", {ctl[3], 23'h0, c[7:0]}, 32'h0);
        low(5);
        wait_cyc(2083);
        low(5);
        wait_cyc(10);
        get_cnt();
        check("overflow", ctl[1], 1'h1);
        check("wrapped", near(c, 10), 1'h1);
        bus(1'h1, sba_pkg::SBA_OFS_CTRL, 32'h20);
        get_cnt();
        check("ovf clear", {ctl[1:0], c[7:0]}, 32'h0);
        for (int k = 0; k < 4; k++) begin
            d = $random(seed) & 3;
            p = 80 + ($random(seed) & 127);
            bus(1'h1, sba_pkg::SBA_OFS_CFG, {16'h0, d[7:0], 7'h0, k[0]});
            if (k == 0) begin
                drive_low <= 1'h1;
                bus(1'h1, sba_pkg::SBA_OFS_CTRL, 32'h30);
                wait_cyc(p);
                drive_low <= 1'h0;
            end else begin
                bus(1'h1, sba_pkg::SBA_OFS_CTRL, 32'h30);
                low(p);
            end
            wait_cyc(10);
            get_cnt();
            d = (k[0] ? 3 : 1) * 2 * (d + 1);
            check("break length", near(c, p / d), 1'h1);
        end
        // Another node holds the line dominant across the sample point
        bus(1'h1, sba_pkg::SBA_OFS_CFG, 32'h0);
        bus(1'h1, sba_pkg::SBA_OFS_CTRL, 32'h80);
        tx_internal <= 1'h0;
        wait_cyc(10);
        tx_internal <= 1'h1;
        wait_cyc(100);
        low(250);
        tx_internal <= 1'h0;
        wait_cyc(5);
        check("forced txd", txd_pin, 1'h1);
        bus(1'h0, sba_pkg::SBA_OFS_CTRL, 32'h0);
        check("lost", r[6], 1'h1);
        bus(1'h1, sba_pkg::SBA_OFS_CTRL, 32'h0);
        wait_cyc(3);
        bus(1'h0, sba_pkg::SBA_OFS_CTRL, 32'h0);
        check("lost clear", r[6], 1'h0);
        check("txd free", txd_pin, 1'h0);
        bus(1'h1, sba_pkg::SBA_OFS_CTRL, 32'h90);
        tx_internal <= 1'h1;
        wait_cyc(60);
        bus(1'h0, sba_pkg::SBA_OFS_CTRL, 32'h0);
        check("no loss", r[6], 1'h0);
        tx_internal <= 1'h0;
        wait_cyc(5);
        get_cnt();
        check("tx low", {ctl[2], 23'h0, c[7:0]}, 32'h0);
        tx_internal <= 1'h1;
        wait_cyc(8);
        bus(1'h0, sba_pkg::SBA_OFS_CTRL, 32'h0);
        check("restart", r[2], 1'h1);
        final_report();
    end
endmodule
